// file: rtl/tsg_start_gate.v
// test start qualification, stop handling and handler output mapping
`timescale 1ns/10ps
`include "tsg_regs.vh"
module tsg_start_gate #(
    parameter MS_DIV   = `TSG_MS_CYCLES,
    parameter WIN_MS   = `TSG_TWO_KEY_MS,
    parameter HOLD_MS  = `TSG_HOLD_START_MS
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [1:0]  start_source_select,
    input  wire        two_key_en,
    input  wire        key_lock_en,
    input  wire        interlock_en,
    input  wire        hold_start_en,
    input  wire        gnd_check_en,
    input  wire        remote_if_active,
    input  wire        auto_mode,
    input  wire        test_per_step,
    input  wire        judge_per_step,
    input  wire        fail_hold_en,
    input  wire [14:0] pin_func,
    input  wire        panel_start,
    input  wire        panel_stop,
    input  wire        rmt_start,
    input  wire        rmt_stop,
    input  wire        io_start,
    input  wire        io_stop,
    input  wire        interlock_closed,
    input  wire        gnd_ok,
    input  wire        edit_key_in,
    input  wire        step_active,
    input  wire        step_done,
    input  wire        step_pass,
    input  wire        step_fail_hi,
    input  wire        step_fail_lo,
    input  wire        last_step,
    output wire        edit_key_out,
    output reg         test_start_ff,
    output reg         test_abort_ff,
    output reg         halt_seq_ff,
    output reg         ready_ff,
    output reg         testing_ff,
    output reg         interlock_open_ff,
    output reg         gnd_fail_ff,
    output reg  [4:0]  handler_out_ff
);
    // states of the test flow
    localparam ST_READY  = 4'b0001;
    localparam ST_TEST   = 4'b0010;
    localparam ST_RESULT = 4'b0100;
    localparam ST_FAIL1  = 4'b1000;

    // pin inputs pass two flip-flops before use
    reg [9:0] sync1_ff;
    reg [9:0] sync2_ff;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_ff <= 10'h000;
            sync2_ff <= 10'h000;
        end
        else
        begin
            sync1_ff <= {gnd_ok, interlock_closed, io_stop, io_start, rmt_stop,
                         rmt_start, panel_stop, panel_start, 2'b00};
            sync2_ff <= sync1_ff;
        end
    end
    wire s_pstart = sync2_ff[2];
    wire s_pstop  = sync2_ff[3];
    wire s_rstart = sync2_ff[4];
    wire s_rstop  = sync2_ff[5];
    wire s_istart = sync2_ff[6];
    wire s_istop  = sync2_ff[7];
    wire s_ilock  = sync2_ff[8];
    wire s_gnd    = sync2_ff[9];

    wire ms_tick;
    tsg_ms_tick #(
        .DIV (MS_DIV)
    ) u_tick (
        .clk     (clk),
        .rst     (rst),
        .tick_ff (ms_tick)
    );

    // source select; panel stop reaches the stop path except under the handler source
    reg src_start;
    reg src_stop;
    always @*
    begin
        case (start_source_select)
            `TSG_SRC_PANEL:   begin src_start = s_pstart; src_stop = s_pstop; end
            `TSG_SRC_REMOTE:  begin src_start = s_rstart; src_stop = s_rstop | s_pstop; end
            `TSG_SRC_HANDLER: begin src_start = s_istart; src_stop = s_istop; end
            default:          begin src_start = 1'b0; src_stop = s_pstop; end
        endcase
    end

    // option changes are plain levels, so they act in the same cycle
    assign edit_key_out = edit_key_in & ~key_lock_en;

    reg start_d_ff;
    reg stop_d_ff;
    wire start_rise = src_start & ~start_d_ff;
    wire stop_rise  = src_stop & ~stop_d_ff;

    // two-key window and held-start counters in ms
    reg        armed_ff;
    reg [15:0] win_ff;
    reg [15:0] hold_ff;
    reg        hold_done_ff;
    wire two_key_on = two_key_en & ~remote_if_active;
    reg  [3:0] state_ff;
    reg  [3:0] nxt_state;
    wire is_ready = state_ff == ST_READY;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            start_d_ff   <= 1'b0;
            stop_d_ff    <= 1'b0;
            armed_ff     <= 1'b0;
            win_ff       <= 16'h0000;
            hold_ff      <= 16'h0000;
            hold_done_ff <= 1'b0;
        end
        else
        begin
            start_d_ff <= src_start;
            stop_d_ff  <= src_stop;
            // arm on STOP in ready, drop when window ends
            if (stop_rise && is_ready)
            begin
                armed_ff <= 1'b1;
                win_ff   <= 16'h0000;
            end
            else if (armed_ff && ms_tick)
            begin
                if (win_ff == WIN_MS - 1)
                    armed_ff <= 1'b0;
                win_ff <= win_ff + 16'h0001;
            end
            if (test_start_ff)
                armed_ff <= 1'b0;
            // hold timer restarts if START lets go early
            if (!src_start || !is_ready)
            begin
                hold_ff      <= 16'h0000;
                hold_done_ff <= 1'b0;
            end
            else if (ms_tick && !hold_done_ff)
            begin
                if (hold_ff == HOLD_MS - 1)
                    hold_done_ff <= 1'b1;
                hold_ff <= hold_ff + 16'h0001;
            end
        end
    end

    // start qualification: edge or completed hold, plus two-key and interlock
    wire hold_fire  = hold_start_en ? (hold_done_ff == 1'b0 && src_start && ms_tick &&
                                       hold_ff == HOLD_MS - 1)
                                    : start_rise;
    wire key_ok     = ~two_key_on | armed_ff;
    wire attempt    = is_ready & hold_fire & key_ok;
    wire ilock_bad  = interlock_en & ~s_ilock;
    wire go         = attempt & ~ilock_bad;

    // halt partway when fail-hold is on and a step fails
    wire step_fail = step_fail_hi | step_fail_lo;
    wire seq_end   = step_done & (last_step | (step_fail & fail_hold_en));

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_READY:  if (go) nxt_state = ST_TEST;
            ST_TEST:
            begin
                if (stop_rise)
                    nxt_state = ST_RESULT;
                else if (seq_end || (step_done && !auto_mode))
                    nxt_state = step_fail ? ST_FAIL1 : ST_RESULT;
            end
            ST_RESULT: if (stop_rise) nxt_state = ST_READY;
            ST_FAIL1:  if (stop_rise) nxt_state = ST_RESULT;
            default:   nxt_state = ST_READY;
        endcase
    end

    // result memory for the judgment pins
    reg pass_ff;
    reg fhi_ff;
    reg flo_ff;
    reg any_fail_ff;
    integer i;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff          <= ST_READY;
            test_start_ff     <= 1'b0;
            test_abort_ff     <= 1'b0;
            halt_seq_ff       <= 1'b0;
            ready_ff          <= 1'b1;
            testing_ff        <= 1'b0;
            interlock_open_ff <= 1'b0;
            gnd_fail_ff       <= 1'b0;
            pass_ff           <= 1'b0;
            fhi_ff            <= 1'b0;
            flo_ff            <= 1'b0;
            any_fail_ff       <= 1'b0;
        end
        else
        begin
            state_ff      <= nxt_state;
            test_start_ff <= go;
            test_abort_ff <= (state_ff == ST_TEST) & stop_rise;
            halt_seq_ff   <= (state_ff == ST_TEST) & step_done & step_fail & fail_hold_en
                             & ~last_step;
            ready_ff      <= nxt_state == ST_READY;
            gnd_fail_ff   <= gnd_check_en & ~s_gnd;
            // blocked attempt raises the flag, held until next good start
            if (attempt && ilock_bad)
                interlock_open_ff <= 1'b1;
            else if (go)
                interlock_open_ff <= 1'b0;
            // testing: whole sequence or one pulse per step
            if (nxt_state != ST_TEST)
                testing_ff <= 1'b0;
            else if (auto_mode && test_per_step)
                testing_ff <= step_active & ~step_done;
            else
                testing_ff <= 1'b1;
            if (go)
            begin
                pass_ff     <= 1'b0;
                fhi_ff      <= 1'b0;
                flo_ff      <= 1'b0;
                any_fail_ff <= 1'b0;
            end
            else if (state_ff == ST_TEST && step_done)
            begin
                if (auto_mode && !judge_per_step)
                begin
                    // accumulate, report once at the end
                    any_fail_ff <= any_fail_ff | step_fail;
                    if (seq_end)
                    begin
                        pass_ff <= ~(any_fail_ff | step_fail);
                        fhi_ff  <= fhi_ff | step_fail_hi;
                        flo_ff  <= flo_ff | step_fail_lo;
                    end
                    else
                    begin
                        fhi_ff <= fhi_ff | step_fail_hi;
                        flo_ff <= flo_ff | step_fail_lo;
                    end
                end
                else
                begin
                    pass_ff <= step_pass & ~step_fail;
                    fhi_ff  <= step_fail_hi;
                    flo_ff  <= step_fail_lo;
                end
            end
            else if (nxt_state == ST_READY && state_ff != ST_READY)
            begin
                pass_ff <= 1'b0;
                fhi_ff  <= 1'b0;
                flo_ff  <= 1'b0;
            end
        end
    end

    // in auto mode without per-step judgment, the final judgment only shows outside the running sequence
    wire show_res = ~(auto_mode & ~judge_per_step) | (state_ff != ST_TEST);

    // map each handler pin to its chosen function
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            handler_out_ff <= 5'h00;
        else
        begin
            for (i = 0; i < 5; i = i + 1)
            begin
                case (pin_func[i*3 +: 3])
                    `TSG_FN_READY:   handler_out_ff[i] <= ready_ff;
                    `TSG_FN_TEST:    handler_out_ff[i] <= testing_ff;
                    `TSG_FN_PASS:    handler_out_ff[i] <= show_res & pass_ff;
                    `TSG_FN_FAIL:    handler_out_ff[i] <= show_res & (fhi_ff | flo_ff);
                    `TSG_FN_FAIL_HI: handler_out_ff[i] <= show_res & fhi_ff;
                    `TSG_FN_FAIL_LO: handler_out_ff[i] <= show_res & flo_ff;
                    default:         handler_out_ff[i] <= 1'b0;
                endcase
            end
        end
    end
endmodule // tsg_start_gate

// file: include/tsg_regs.vh
// constants for the test start gating block
`ifndef TSG_REGS_VH
`define TSG_REGS_VH
`define TSG_CLK_HZ          50000000
`define TSG_MS_CYCLES       (`TSG_CLK_HZ / 1000)
`define TSG_TWO_KEY_MS      500
`define TSG_HOLD_START_MS   1000
`define TSG_SRC_PANEL       2'h0
`define TSG_SRC_REMOTE      2'h1
`define TSG_SRC_HANDLER     2'h2
`define TSG_FN_READY        3'h0
`define TSG_FN_TEST         3'h1
`define TSG_FN_PASS         3'h2
`define TSG_FN_FAIL         3'h3
`define TSG_FN_FAIL_HI      3'h4
`define TSG_FN_FAIL_LO      3'h5
`endif

// file: rtl/tsg_ms_tick.v
// millisecond enable divider
`timescale 1ns/10ps
module tsg_ms_tick #(
    parameter DIV = 50000
) (
    input  wire clk,
    input  wire rst,
    output reg  tick_ff
);
    reg [31:0] cnt_ff;
    // one-cycle pulse every DIV clocks
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff  <= 32'h0;
            tick_ff <= 1'b0;
        end
        else if (cnt_ff == DIV - 1)
        begin
            cnt_ff  <= 32'h0;
            tick_ff <= 1'b1;
        end
        else
        begin
            cnt_ff  <= cnt_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end
endmodule // tsg_ms_tick

// file: test/tsg_gate_chk.sv
// port assertions and covers for the start gate
`timescale 1ns/10ps
module tsg_gate_chk (
    input wire clk,
    input wire rst,
    input wire key_lock_en,
    input wire interlock_en,
    input wire gnd_check_en,
    input wire auto_mode,
    input wire fail_hold_en,
    input wire interlock_closed,
    input wire gnd_ok,
    input wire edit_key_in,
    input wire step_done,
    input wire step_fail_hi,
    input wire step_fail_lo,
    input wire last_step,
    input wire edit_key_out,
    input wire test_start_ff,
    input wire test_abort_ff,
    input wire halt_seq_ff,
    input wire ready_ff,
    input wire testing_ff,
    input wire gnd_fail_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // start pulses only from ready and hand over to testing
    // ready drops on the same edge that launches the start pulse
    a_start_in_ready: assert property (test_start_ff |-> !ready_ff && $past(ready_ff))
        else $error("start outside ready");
    a_start_to_test: assert property (test_start_ff |=> !test_start_ff && !ready_ff)
        else $error("start not followed by testing");
    a_lock_edit_mask: assert property (edit_key_out == (edit_key_in && !key_lock_en))
        else $error("edit key not masked by lock");
    a_ilock_blocks: assert property (test_start_ff |-> !interlock_en || interlock_closed)
        else $error("start with interlock open");
    // five cycles covers the two sync stages plus the flag register
    a_gnd_fail_flag: assert property ((gnd_check_en && !gnd_ok) [*5] |-> gnd_fail_ff)
        else $error("ground fail not flagged");
    // per-step testing pin may be low at step end, so use not-ready instead
    a_halt_on_fail: assert property (auto_mode && fail_hold_en && !ready_ff && step_done
        && (step_fail_hi || step_fail_lo) && !last_step |-> ##[1:2] halt_seq_ff)
        else $error("no halt at failing step");
    a_halt_one_cycle: assert property (halt_seq_ff |=> !halt_seq_ff)
        else $error("halt pulse too long");
    a_abort_in_test: assert property (test_abort_ff |-> !ready_ff ##1 !test_abort_ff)
        else $error("abort outside test");
    c_start: cover property (test_start_ff);
    c_abort: cover property (test_abort_ff);
    c_halt: cover property (halt_seq_ff);
endmodule // tsg_gate_chk

bind tsg_start_gate tsg_gate_chk u_chk (.*);

// file: test/tsg_op_model.sv
// operator side model: panel keys, remote box and handler port buttons
`timescale 1ns/10ps
module tsg_op_model (
    input  wire [1:0] psrc,
    input  wire       start_on,
    input  wire       stop_on,
    output wire       panel_start,
    output wire       panel_stop,
    output wire       rmt_start,
    output wire       rmt_stop,
    output wire       io_start,
    output wire       io_stop
);
    // only the pressing source moves; idle buttons rest low
    assign panel_start = start_on && (psrc == 2'h0);
    assign rmt_start   = start_on && (psrc == 2'h1);
    assign io_start    = start_on && (psrc == 2'h2);
    // panel stop reaches the gate under the panel and remote sources, not the handler source
    assign panel_stop  = stop_on && (psrc == 2'h0);
    assign rmt_stop    = stop_on && (psrc == 2'h1);
    assign io_stop     = stop_on && (psrc == 2'h2);
endmodule // tsg_op_model

// file: test/tb.sv
// self-checking bench for the start gate
`timescale 1ns/10ps
module tb;
    logic        clk = 1'h0, rst = 1'h1;
    logic [1:0]  start_source_select = 2'h0, psrc = 2'h0;
    logic        two_key_en = 0, key_lock_en = 0, interlock_en = 0, hold_start_en = 0;
    logic        gnd_check_en = 0, remote_if_active = 0, auto_mode = 0, test_per_step = 0;
    logic        judge_per_step = 0, fail_hold_en = 0, start_on = 0, stop_on = 0;
    logic [14:0] pin_func = 15'h4688; // pins: ready, testing, pass, fail, fail-hi
    logic        interlock_closed = 1, gnd_ok = 1, edit_key_in = 0, step_active = 0;
    logic        step_done = 0, step_pass = 0, step_fail_hi = 0, step_fail_lo = 0, last_step = 0;
    wire         panel_start, panel_stop, rmt_start, rmt_stop, io_start, io_stop;
    wire         edit_key_out, test_start_ff, test_abort_ff, halt_seq_ff, ready_ff;
    wire         testing_ff, interlock_open_ff, gnd_fail_ff;
    wire [4:0]   handler_out_ff;
    logic [10:0] rows [0:10]; // sel, src, stop kind, two-key, ilock en, closed, remote, expect
    int          fail_count = 0, cmp_count = 0, n_st = 0, n_ab = 0, n_hl = 0, n0, i;

    tsg_start_gate #(.MS_DIV(4), .WIN_MS(5), .HOLD_MS(10)) dut (.*);
    tsg_op_model u_op (.*);

    always #10 clk = ~clk;
    // pulse counters so tests need not catch the exact cycle
    always @(posedge clk)
    begin
        n_st <= n_st + int'(test_start_ff === 1'h1);
        n_ab <= n_ab + int'(test_abort_ff === 1'h1);
        n_hl <= n_hl + int'(halt_seq_ff === 1'h1);
    end

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp);
        end
    endtask
    task press(input logic [1:0] s, input logic k, input int n);
        psrc = s;
        start_on = k;
        stop_on = !k;
        cyc(n);
        start_on = 0;
        stop_on = 0;
        cyc(4);
    endtask
    // end the sequence with one result, then walk back to ready
    task fin(input logic f);
        step_done = 1;
        last_step = 1;
        step_pass = !f;
        step_fail_hi = f;
        cyc(1);
        step_done = 0;
        last_step = 0;
        step_pass = 0;
        step_fail_hi = 0;
        cyc(3);
        chk(handler_out_ff, f ? 8'h18 : 8'h04);
        press(start_source_select, 1'h0, 3);
        if (f) chk(ready_ff, 1'h0);
        if (f) press(start_source_select, 1'h0, 3);
        chk(ready_ff, 1'h1);
    endtask
    task rdy;
        repeat (2) if (ready_ff !== 1'h1) press(start_source_select, 1'h0, 3);
        chk(ready_ff, 1'h1);
    endtask
    task tally_and_finish;
        $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #120000;
        fail_count++;
        tally_and_finish;
    end

    initial
    begin
        rows[0] = {2'h0, 2'h0, 2'h0, 5'h05};
        rows[1] = {2'h0, 2'h1, 2'h0, 5'h04};
        rows[2] = {2'h1, 2'h1, 2'h0, 5'h05};
        rows[3] = {2'h2, 2'h2, 2'h0, 5'h05};
        rows[4] = {2'h2, 2'h0, 2'h0, 5'h04};
        rows[5] = {2'h0, 2'h0, 2'h0, 5'h14};
        rows[6] = {2'h0, 2'h0, 2'h1, 5'h15};
        rows[7] = {2'h0, 2'h0, 2'h2, 5'h14};
        rows[8] = {2'h0, 2'h0, 2'h0, 5'h17};
        rows[9] = {2'h0, 2'h0, 2'h0, 5'h08};
        rows[10] = {2'h0, 2'h0, 2'h0, 5'h0D};
        cyc(12);
        chk(ready_ff, 1'h1);
        chk(handler_out_ff, 8'h00);
        chk(test_start_ff, 1'h0);
        rst = 0;
        cyc(4);
        // option changes act on the very next attempt
        for (i = 0; i <= 10; i++)
        begin
            start_source_select = rows[i][10:9];
            two_key_en = rows[i][4];
            interlock_en = rows[i][3];
            interlock_closed = rows[i][2];
            remote_if_active = rows[i][1];
            cyc(4);
            n0 = n_st;
            if (rows[i][6:5] != 2'h0) press(rows[i][8:7], 1'h0, 2);
            if (rows[i][6:5] == 2'h2) cyc(30);
            press(rows[i][8:7], 1'h1, 3);
            chk(8'(n_st - n0), rows[i][0]);
            chk(interlock_open_ff, rows[i][3] && !rows[i][2]);
            if (rows[i][0]) fin(1'h0);
        end
        // held start: early release restarts the hold timer
        two_key_en = 0;
        hold_start_en = 1;
        n0 = n_st;
        press(2'h0, 1'h1, 24);
        psrc = 2'h0;
        start_on = 1;
        cyc(36);
        chk(8'(n_st - n0), 8'h00);
        cyc(16);
        chk(8'(n_st - n0), 8'h01);
        start_on = 0;
        cyc(4);
        hold_start_en = 0;
        chk(testing_ff, 1'h1);
        fin(1'h1);
        // auto mode, per-step pins, panel abort under remote control
        chk(handler_out_ff, 8'h01);
        start_source_select = 2'h1;
        auto_mode = 1;
        test_per_step = 1;
        judge_per_step = 1;
        fail_hold_en = 1;
        press(2'h1, 1'h1, 3);
        step_active = 1;
        cyc(4);
        chk(handler_out_ff[1], 1'h1);
        step_active = 0;
        step_done = 1;
        step_pass = 1;
        cyc(1);
        step_done = 0;
        cyc(3);
        chk(handler_out_ff[1], 1'h0);
        chk(handler_out_ff[2], 1'h1);
        n0 = n_ab;
        press(2'h0, 1'h0, 3);
        chk(8'(n_ab - n0), 8'h01);
        rdy;
        press(2'h1, 1'h1, 3);
        n0 = n_hl;
        step_done = 1;
        step_fail_lo = 1;
        cyc(1);
        step_done = 0;
        step_fail_lo = 0;
        cyc(3);
        chk(8'(n_hl - n0), 8'h01);
        rdy;
        // ground check and key lock
        gnd_check_en = 1;
        gnd_ok = 0;
        cyc(6);
        chk(gnd_fail_ff, 1'h1);
        gnd_ok = 1;
        cyc(6);
        chk(gnd_fail_ff, 1'h0);
        key_lock_en = 1;
        edit_key_in = 1;
        cyc(1);
        chk(edit_key_out, 1'h0);
        key_lock_en = 0;
        cyc(1);
        chk(edit_key_out, 1'h1);
        tally_and_finish;
    end
endmodule // tb
